/* File: inc/eid_pkg.sv */
// Constants and types for the extended instruction decoder
package eid_pkg;
	localparam int          PTR_W        = 12;
	localparam int          LIT_W        = 6;
	localparam int          PC_W         = 21;
	localparam int          EXT_COUNT    = 8;
	localparam logic [7:0]  OPC_PTR_ADD  = 8'he8;
	localparam logic [7:0]  OPC_PTR_SUB  = 8'he9;
	localparam logic [7:0]  OPC_PUSH     = 8'hea;
	localparam logic [7:0]  OPC_MOVE     = 8'heb;
	localparam logic [15:0] WORD_CALL_W  = 16'h0014;
	localparam logic [3:0]  PFX_SECOND   = 4'hf;
	localparam logic [1:0]  SEL_TWO_RET  = 2'h3;
	localparam logic [7:0]  IDX_FILE_MAX = 8'h5f;
	localparam logic [11:0] PTR_RST      = 12'h000;
	localparam logic [11:0] PTR_DEC      = 12'h001;
	localparam int          SEL_HI       = 7;
	localparam int          SEL_LO       = 6;
	localparam int          MOVE_DIR_BIT = 7;
	localparam int          ACCESS_BIT   = 8;

	typedef enum logic [3:0] {
		PH_Q1 = 4'h1,
		PH_Q2 = 4'h2,
		PH_Q3 = 4'h4,
		PH_Q4 = 4'h8
	} eid_phase_e;

	typedef enum logic [1:0] {
		ST_FIRST  = 2'h1,
		ST_SECOND = 2'h2
	} eid_state_e;
endpackage

/* File: testbench/eid_decoder_bench.sv */
// Self-checking bench for the extended instruction decoder
module eid_decoder_bench;
	timeunit 1ns;
	timeprecision 1ps;
	logic        sys_clk = 1'b0;
	logic        rst_b = 1'b0;
	logic        cfgExtEnable = 1'b0;
	logic        instrValid = 1'b0;
	logic        stdFileOp = 1'b0;
	logic [15:0] instrWord = 16'h0000;
	logic [7:0]  wregIn = 8'h3c;
	logic [7:0]  memRdData = 8'h00;
	logic [20:0] tosIn = 21'h0a5a5;
	logic [12:0] pcLatchIn = 13'h0123;
	logic        phaseQ1_q, extEnabled_q, memRdEn_q, memWrEn_q, pcLoad_q;
	logic        retPush_q, retPop_q, busy_q, extHit_q, idxMode_q;
	logic [11:0] ptr0, ptr1, ptr2, memAddr_q, idxAddr_q;
	logic [7:0]  memWrData_q;
	logic [20:0] pcValue_q;
	int          n_errors = 0;
	int          tests_run = 0;
	wire  [5:0]  strobes = {memRdEn_q, memWrEn_q, pcLoad_q, retPush_q, retPop_q, extHit_q};

	eid_decoder uut (
		.sys_clk(sys_clk), .rst_b(rst_b), .cfgExtEnable(cfgExtEnable), .instrValid(instrValid),
		.instrWord(instrWord), .stdFileOp(stdFileOp), .wregIn(wregIn), .tosIn(tosIn),
		.pcLatchIn(pcLatchIn), .memRdData(memRdData), .phaseQ1_q(phaseQ1_q), .extEnabled_q(extEnabled_q),
		.ptr0(ptr0), .ptr1(ptr1), .ptr2(ptr2), .memRdEn_q(memRdEn_q), .memWrEn_q(memWrEn_q),
		.memAddr_q(memAddr_q), .memWrData_q(memWrData_q), .pcLoad_q(pcLoad_q), .pcValue_q(pcValue_q),
		.retPush_q(retPush_q), .retPop_q(retPop_q), .busy_q(busy_q), .extHit_q(extHit_q),
		.idxMode_q(idxMode_q), .idxAddr_q(idxAddr_q)
	);

	always #10 sys_clk = ~sys_clk;

	task automatic tick();
		@(posedge sys_clk);
		#2;
	endtask

	task automatic check(input string name, input logic [63:0] seen, input logic [63:0] exp);
		tests_run++;
		if (seen !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask

	// Present one word in the next Q1 clock, drop it after capture
	task automatic issue(input logic [15:0] w, input logic std);
		int n;
		n = 0;
		while (phaseQ1_q !== 1'b1 && n < 8) begin
			tick();
			n++;
		end
		instrValid = 1'b1;
		instrWord = w;
		stdFileOp = std;
		tick();
		instrValid = 1'b0;
		stdFileOp = 1'b0;
	endtask

	// Returns in the clock where execution strobes stand
	task automatic exec(input logic [15:0] w);
		issue(w, 1'b0);
		repeat (3) tick();
	endtask

	task automatic do_reset(input logic en);
		rst_b = 1'b0;
		cfgExtEnable = en;
		repeat (6) tick();
		rst_b = 1'b1;
		repeat (5) tick();
		check("extEnabled", extEnabled_q, en);
	endtask

	task automatic t_disabled();
		logic [15:0] w [4];
		w = '{16'he805, 16'hea77, 16'h0014, 16'he8c3};
		do_reset(1'b0);
		foreach (w[i]) begin
			exec(w[i]);
			check("offStrobes", {strobes, busy_q}, 7'h00);
		end
		check("offPtrs", {ptr0, ptr1, ptr2}, 36'h0);
		issue(16'h0010, 1'b1);
		check("offIdx", idxMode_q, 1'b0);
	endtask

	task automatic t_ptr();
		for (int s = 0; s < 3; s++) begin
			exec({8'he8, s[1:0], 6'h3f - s[5:0]});
			check("addStrobes", strobes, 6'h01);
		end
		exec(16'he97f);
		check("subStrobes", strobes, 6'h01);
		check("ptrs", {ptr0, ptr1, ptr2}, {12'h03f, 12'hfff, 12'h03d});
		exec(16'hea5a);
		check("pushStrobes", strobes, 6'h11);
		check("pushAddr", {memAddr_q, memWrData_q}, {12'h03d, 8'h5a});
		check("pushPtr2", ptr2, 12'h03c);
	endtask

	task automatic t_return();
		for (int i = 0; i < 2; i++) begin
			exec({i ? 8'he9 : 8'he8, 8'hc4});
			check("retStrobes", {strobes, busy_q}, 7'h17);
			check("retPc", pcValue_q, tosIn);
			check("retPtr2", ptr2, i ? 12'h03c : 12'h040);
			repeat (3) begin
				tick();
				check("retQuiet", {strobes, busy_q}, 7'h01);
			end
			tick();
			check("retDone", busy_q, 1'b0);
		end
	endtask

	task automatic t_call();
		exec(16'h0014);
		check("callStrobes", {strobes, busy_q}, 7'h1b);
		check("callPc", pcValue_q, {pcLatchIn, wregIn});
		repeat (4) tick();
		check("callDone", busy_q, 1'b0);
		check("callPtrs", {ptr0, ptr1, ptr2}, {12'h03f, 12'hfff, 12'h03c});
	endtask

	task automatic t_move();
		for (int i = 0; i < 2; i++) begin
			exec(i ? 16'heb85 : 16'heb05);
			check("mvRead", {memRdEn_q, memAddr_q}, {1'b1, 12'h041});
			issue(i ? 16'hf00a : 16'hf123, 1'b0);
			memRdData = 8'hc7 + i[7:0];
			repeat (3) tick();
			check("mvWrite", {memWrEn_q, memAddr_q}, {1'b1, i ? 12'h046 : 12'h123});
			check("mvData", memWrData_q, 8'hc7 + i[7:0]);
		end
	endtask

	task automatic t_index();
		issue(16'h005f, 1'b1);
		check("idxOn", {idxMode_q, idxAddr_q}, {1'b1, 12'h09b});
		issue(16'h0060, 1'b1);
		check("idxHigh", idxMode_q, 1'b0);
		issue(16'h015f, 1'b1);
		check("idxBank", idxMode_q, 1'b0);
	endtask

	task automatic give_verdict();
		$display("Errors %0d, checks %0d", n_errors, tests_run);
		if (n_errors == 0 && tests_run > 0) begin
			$display("Run complete: PASS");
		end else begin
			$display("Run complete: FAIL");
		end
		$finish;
	endtask

	initial begin
		#100000;
		n_errors++;
		give_verdict();
	end

	initial begin
		t_disabled();
		do_reset(1'b1);
		t_ptr();
		t_return();
		t_call();
		t_move();
		t_index();
		give_verdict();
	end
endmodule

/* File: verilog/eid_decoder.sv */
// Extended instruction decoder and executor
// Notes on behaviour
// - Extension stays off unless the enable configuration bit is set.
// - Enabled: eight added instructions plus indexed literal offset addressing.
// - Pointer add/sub words E8/E9: two-bit select, six-bit literal, one cycle.
// - Select 11 means pointer-two add/sub and return, two cycles, no flags.
// - Return variants adjust pointer two, then return automatically.
// - Word 0014h calls through working register, two cycles, no flags.
// - Push literal stores at pointer two, decrements pointer two, one cycle.
// - Indexed moves: two words, two cycles, bit 7 picks file or indexed.
// - Other extended instructions are literal ops on file select pointers.
// - Access bit 0 and file operand at most 5Fh selects indexed addressing.
// - Add-and-return loads PC from stack top, second cycle does nothing.
// - Pointer add adds unsigned literal 0..63 to pointer zero, one or two.
module eid_decoder #(
	parameter int PTR_W = eid_pkg::PTR_W,
	parameter int PC_W  = eid_pkg::PC_W
) (
	input  wire logic              sys_clk,
	input  wire logic              rst_b,
	input  wire logic              cfgExtEnable,
	input  wire logic              instrValid,
	input  wire logic [15:0]       instrWord,
	input  wire logic              stdFileOp,
	input  wire logic [7:0]        wregIn,
	input  wire logic [PC_W-1:0]   tosIn,
	input  wire logic [PC_W-9:0]   pcLatchIn,
	input  wire logic [7:0]        memRdData,
	output logic                   phaseQ1_q,
	output logic                   extEnabled_q,
	output logic [PTR_W-1:0]       ptr0,
	output logic [PTR_W-1:0]       ptr1,
	output logic [PTR_W-1:0]       ptr2,
	output logic                   memRdEn_q,
	output logic                   memWrEn_q,
	output logic [PTR_W-1:0]       memAddr_q,
	output logic [7:0]             memWrData_q,
	output logic                   pcLoad_q,
	output logic [PC_W-1:0]        pcValue_q,
	output logic                   retPush_q,
	output logic                   retPop_q,
	output logic                   busy_q,
	output logic                   extHit_q,
	output logic                   idxMode_q,
	output logic [PTR_W-1:0]       idxAddr_q
);
	eid_pkg::eid_phase_e phase_q;
	eid_pkg::eid_phase_e phase_d;
	eid_pkg::eid_state_e state_q;
	eid_pkg::eid_state_e state_d;

	logic             cfgTaken_q;
	logic             have_q;
	logic             moving_q;
	logic [15:0]      word_q;
	logic [15:0]      word2_q;
	logic [7:0]       moveData_q;
	logic [PTR_W-1:0] ptr_q [3];
	logic [PTR_W-1:0] ptr_d [3];
	logic [PTR_W-1:0] aluRes [3];

	assign ptr0 = ptr_q[0];
	assign ptr1 = ptr_q[1];
	assign ptr2 = ptr_q[2];

	// Phase ring and instruction-cycle strobes
	always_comb begin
		unique case (phase_q)
			eid_pkg::PH_Q1: phase_d = eid_pkg::PH_Q2;
			eid_pkg::PH_Q2: phase_d = eid_pkg::PH_Q3;
			eid_pkg::PH_Q3: phase_d = eid_pkg::PH_Q4;
			eid_pkg::PH_Q4: phase_d = eid_pkg::PH_Q1;
			default:        phase_d = eid_pkg::PH_Q1;
		endcase
	end

	wire logic inFirst  = (state_q == eid_pkg::ST_FIRST);
	wire logic inSecond = (state_q == eid_pkg::ST_SECOND);
	wire logic atQ1     = (phase_q == eid_pkg::PH_Q1);
	wire logic atQ2     = (phase_q == eid_pkg::PH_Q2);
	wire logic atQ4     = (phase_q == eid_pkg::PH_Q4);
	wire logic take     = atQ1 & instrValid;

	// Extended decode, every match gated by the enable bit
	wire logic [7:0]       hiOp    = word_q[15:8];
	wire logic [1:0]       ptrSel  = word_q[eid_pkg::SEL_HI:eid_pkg::SEL_LO];
	wire logic [5:0]       lit6    = word_q[5:0];
	wire logic             isAdd   = extEnabled_q & (hiOp == eid_pkg::OPC_PTR_ADD);
	wire logic             isSub   = extEnabled_q & (hiOp == eid_pkg::OPC_PTR_SUB);
	wire logic             isPush  = extEnabled_q & (hiOp == eid_pkg::OPC_PUSH);
	wire logic             isMove  = extEnabled_q & (hiOp == eid_pkg::OPC_MOVE);
	wire logic             isCall  = extEnabled_q & (word_q == eid_pkg::WORD_CALL_W);
	wire logic             isArith = isAdd | isSub;
	wire logic             retVar  = isArith & (ptrSel == eid_pkg::SEL_TWO_RET);
	wire logic [1:0]       tgtPtr  = retVar ? 2'h2 : ptrSel;
	wire logic             anyExt  = isArith | isPush | isMove | isCall;
	wire logic             execute = have_q & atQ4 & inFirst;
	wire logic             twoCyc  = retVar | isCall | isMove;
	wire logic             finish  = inSecond & atQ4;
	wire logic [PTR_W-1:0] pushDec = ptr_q[2] - eid_pkg::PTR_DEC;
	wire logic [PTR_W-1:0] srcAddr = ptr_q[2] + {5'h0, word_q[6:0]};
	wire logic [PTR_W-1:0] dstIdx  = ptr_q[2] + {5'h0, word2_q[6:0]};
	wire logic [PTR_W-1:0] dstAddr = word_q[eid_pkg::MOVE_DIR_BIT] ? dstIdx : word2_q[11:0];
	wire logic [PTR_W-1:0] stdIdx  = ptr_q[2] + {4'h0, instrWord[7:0]};
	wire logic             stdIdxD = extEnabled_q & stdFileOp & ~instrWord[eid_pkg::ACCESS_BIT]
	                                 & (instrWord[7:0] <= eid_pkg::IDX_FILE_MAX);

	genvar gi;
	generate
		for (gi = 0; gi < 3; gi++) begin : g_ptr
			eid_ptr_alu #(.W(PTR_W), .LW(eid_pkg::LIT_W)) u_alu (
				.opA      (ptr_q[gi]),
				.lit      (lit6),
				.subtract (isSub),
				.result   (aluRes[gi])
			);
			wire logic arithHit = execute & isArith & (tgtPtr == 2'(gi));
			wire logic pushHit  = execute & isPush & (gi == 2);
			assign ptr_d[gi] = arithHit ? aluRes[gi] : (pushHit ? pushDec : ptr_q[gi]);
		end
	endgenerate

	assign state_d = (execute & twoCyc) ? eid_pkg::ST_SECOND :
	                 (finish ? eid_pkg::ST_FIRST : state_q);

	wire logic             wrPush  = execute & isPush;
	wire logic             wrMove  = finish & moving_q;
	wire logic             pcLdD   = execute & (retVar | isCall);
	wire logic [PC_W-1:0]  pcD     = retVar ? tosIn : {pcLatchIn, wregIn};
	wire logic [PTR_W-1:0] addrD   = wrPush ? ptr_q[2] : (wrMove ? dstAddr : srcAddr);
	wire logic [7:0]       wrDataD = wrPush ? word_q[7:0] : moveData_q;

	// Configuration bit caught once after reset release
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			cfgTaken_q   <= 1'b0;
			extEnabled_q <= 1'b0;
		end else if (!cfgTaken_q) begin
			cfgTaken_q   <= 1'b1;
			extEnabled_q <= cfgExtEnable;
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			phase_q   <= eid_pkg::PH_Q1;
			phaseQ1_q <= 1'b1;
			state_q   <= eid_pkg::ST_FIRST;
			busy_q    <= 1'b0;
			for (int i = 0; i < 3; i++) begin
				ptr_q[i] <= eid_pkg::PTR_RST;
			end
		end else begin
			phase_q   <= phase_d;
			phaseQ1_q <= (phase_d == eid_pkg::PH_Q1);
			state_q   <= state_d;
			busy_q    <= (state_d == eid_pkg::ST_SECOND);
			for (int i = 0; i < 3; i++) begin
				ptr_q[i] <= ptr_d[i];
			end
		end
	end

	// Instruction capture at Q1
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			have_q    <= 1'b0;
			word_q    <= 16'h0000;
			word2_q   <= 16'h0000;
			idxMode_q <= 1'b0;
			idxAddr_q <= eid_pkg::PTR_RST;
		end else if (atQ1) begin
			if (inFirst) begin
				have_q    <= take;
				word_q    <= instrWord;
				idxMode_q <= take & stdIdxD;
				idxAddr_q <= stdIdx;
			end else begin
				have_q    <= 1'b0;
				idxMode_q <= 1'b0;
				if (take & (instrWord[15:12] == eid_pkg::PFX_SECOND)) begin
					word2_q <= instrWord;
				end
			end
		end
	end

	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			moving_q   <= 1'b0;
			moveData_q <= 8'h00;
		end else begin
			if (execute) begin
				moving_q <= isMove;
			end else if (finish) begin
				moving_q <= 1'b0;
			end
			if (inSecond & atQ2 & moving_q) begin
				moveData_q <= memRdData;
			end
		end
	end

	// One-cycle strobes toward the core
	always_ff @(posedge sys_clk) begin
		if (!rst_b) begin
			memRdEn_q   <= 1'b0;
			memWrEn_q   <= 1'b0;
			memAddr_q   <= eid_pkg::PTR_RST;
			memWrData_q <= 8'h00;
			pcLoad_q    <= 1'b0;
			pcValue_q   <= '0;
			retPush_q   <= 1'b0;
			retPop_q    <= 1'b0;
			extHit_q    <= 1'b0;
		end else begin
			memRdEn_q   <= execute & isMove;
			memWrEn_q   <= wrPush | wrMove;
			memAddr_q   <= addrD;
			memWrData_q <= wrDataD;
			pcLoad_q    <= pcLdD;
			pcValue_q   <= pcD;
			retPush_q   <= execute & isCall;
			retPop_q    <= execute & retVar;
			extHit_q    <= execute & anyExt;
		end
	end

	sequence s_move_read;
		memRdEn_q ##4 (memWrEn_q && memAddr_q == dstAddr);
	endsequence
	sequence s_quiet_cycle;
		(!memWrEn_q && !pcLoad_q && !extHit_q)[*4];
	endsequence

	property p_cfg_gate;
		@(posedge sys_clk) disable iff (!rst_b) !extEnabled_q |-> !extHit_q && !idxMode_q && !memRdEn_q;
	endproperty
	a_cfg_gate: assert property (p_cfg_gate) else $error("Extension acted while disabled");

	property p_arith_one;
		@(posedge sys_clk) disable iff (!rst_b) execute && isArith && !retVar |=> !busy_q && !pcLoad_q;
	endproperty
	a_arith_one: assert property (p_arith_one) else $error("Pointer add or sub took extra cycle");

	property p_add_value;
		@(posedge sys_clk) disable iff (!rst_b) execute && isAdd && ptrSel == 2'h0 |=> ptr_q[0] == $past(aluRes[0]);
	endproperty
	a_add_value: assert property (p_add_value) else $error("Pointer zero not updated by add");

	property p_ret;
		@(posedge sys_clk) disable iff (!rst_b)
			execute && retVar |=> pcLoad_q && retPop_q && busy_q && pcValue_q == $past(tosIn);
	endproperty
	a_ret: assert property (p_ret) else $error("Return variant did not load stack top");

	property p_ret_nop;
		@(posedge sys_clk) disable iff (!rst_b) execute && retVar |=> ##1 s_quiet_cycle;
	endproperty
	a_ret_nop: assert property (p_ret_nop) else $error("Second return cycle was not idle");

	property p_call;
		@(posedge sys_clk) disable iff (!rst_b)
			execute && isCall |=> retPush_q && pcLoad_q && pcValue_q == {$past(pcLatchIn), $past(wregIn)};
	endproperty
	a_call: assert property (p_call) else $error("Call target not from working register");

	property p_push;
		@(posedge sys_clk) disable iff (!rst_b)
			execute && isPush |=> memWrEn_q && memAddr_q == $past(ptr_q[2])
			&& ptr_q[2] == $past(ptr_q[2]) - eid_pkg::PTR_DEC && !busy_q;
	endproperty
	a_push: assert property (p_push) else $error("Push literal store or decrement wrong");

	property p_move;
		@(posedge sys_clk) disable iff (!rst_b) execute && isMove |=> s_move_read;
	endproperty
	a_move: assert property (p_move) else $error("Indexed move sequence wrong");

	property p_idx;
		@(posedge sys_clk) disable iff (!rst_b)
			take && inFirst && stdIdxD |=> idxMode_q && idxAddr_q == $past(stdIdx);
	endproperty
	a_idx: assert property (p_idx) else $error("Indexed literal offset not applied");
endmodule

/* File: verilog/eid_ptr_alu.sv */
// Pointer add or subtract of a zero-extended literal
module eid_ptr_alu #(
	parameter int W  = 12,
	parameter int LW = 6
) (
	input  wire logic [W-1:0]  opA,
	input  wire logic [LW-1:0] lit,
	input  wire logic          subtract,
	output logic      [W-1:0]  result
);
	wire logic [W-1:0] litExt = {{(W-LW){1'b0}}, lit};

	assign result = subtract ? (opA - litExt) : (opA + litExt);
endmodule
